// [chc_consts.svh]
// Constants for the CAN host controller: device map, field positions, own register map
`ifndef CHC_CONSTS_SVH
`define CHC_CONSTS_SVH

// ----------------------------------------------------------------
// Device register offsets (byte addresses on the device bus)
// ----------------------------------------------------------------
`define CHC_DEV_MCTRL       12'h000
`define CHC_DEV_MSTS        12'h004
`define CHC_DEV_TSTS        12'h008
`define CHC_DEV_RFF0        12'h00c
`define CHC_DEV_RFF1        12'h010
`define CHC_DEV_BTIM        12'h01c
`define CHC_DEV_TX_BASE     12'h180
`define CHC_DEV_RX_BASE     12'h1b0
`define CHC_DEV_FMC         12'h200
`define CHC_DEV_FM1         12'h204
`define CHC_DEV_FS1         12'h20c
`define CHC_DEV_FFA1        12'h214
`define CHC_DEV_FA1         12'h21c
`define CHC_DEV_FILT_BASE   12'h240

// ----------------------------------------------------------------
// Device field positions
// ----------------------------------------------------------------
`define CHC_MCTRL_INIT_BIT  0
`define CHC_MCTRL_SLEEP_BIT 1
`define CHC_MSTS_ACK_BIT    0
`define CHC_FMC_LOCK_BIT    0
`define CHC_TSTS_EMPTY_LSB  26
`define CHC_TXID_REQ_BIT    0
`define CHC_RFF_PEND_LSB    0
`define CHC_RFF_REL_BIT     5
`define CHC_BTIM_TS1_LSB    16
`define CHC_BTIM_TS2_LSB    20
`define CHC_BTIM_MASK       32'hc3ff_03ff

// ----------------------------------------------------------------
// Own register offsets and command bits
// ----------------------------------------------------------------
`define CHC_REG_CMD         8'h00
`define CHC_REG_STATUS      8'h04
`define CHC_REG_TIMING      8'h08
`define CHC_REG_OPTIONS     8'h0c
`define CHC_REG_FMODE       8'h10
`define CHC_REG_FSCALE      8'h14
`define CHC_REG_FASSIGN     8'h18
`define CHC_REG_FACT        8'h1c
`define CHC_REG_FIDX        8'h20
`define CHC_REG_FVAL1       8'h24
`define CHC_REG_FVAL2       8'h28
`define CHC_REG_TX_HI       4'h3
`define CHC_REG_RX_HI       4'h4
`define CHC_CMD_CFG_BIT     0
`define CHC_CMD_TX_BIT      1
`define CHC_CMD_RX_BIT      2
`define CHC_CMD_FIFO_BIT    3
`define CHC_TIMING_RESET    32'h0005_0003

`endif

// [chc_pkg.sv]
// Types for the CAN host controller
package chc_pkg;

  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    CHC_S_IDLE   = 4'b0001,
    CHC_S_STEP   = 4'b0010,
    CHC_S_SETUP  = 4'b0100,
    CHC_S_ACCESS = 4'b1000
  } chc_state_t;

  // Device mode as tracked by the host, one-hot
  typedef enum logic [3:0] {
    CHC_M_SLEEP  = 4'b0001,
    CHC_M_AWAKE  = 4'b0010,
    CHC_M_INIT   = 4'b0100,
    CHC_M_NORMAL = 4'b1000
  } chc_mode_t;

  typedef enum logic [1:0] {
    CHC_OP_CFG = 2'h0,
    CHC_OP_TX  = 2'h1,
    CHC_OP_RX  = 2'h2
  } chc_op_t;

  typedef enum logic [1:0] {
    CHC_K_END = 2'h0,
    CHC_K_WR  = 2'h1,
    CHC_K_RD  = 2'h2
  } chc_kind_t;

  // One device access of a sequence
  typedef struct packed {
    chc_kind_t   kind;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic        poll;
    logic        poll_val;
  } chc_step_t;

  // Master request toward the device
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } chc_apb_req_t;

  // Device answer
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } chc_apb_rsp_t;

endpackage

// [chc_host.sv]
// CAN host controller: sequences mode, timing, filter, mailbox and FIFO accesses
`timescale 1ns/100ps
`include "chc_consts.svh"
module chc_host
  import chc_pkg::*;
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic      [31:0]  prdata,
  output logic              pready,
  output logic              pslverr,
  output chc_apb_req_t      m_req,
  input  chc_apb_rsp_t      m_rsp
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  chc_state_t   state_q;
  chc_mode_t    mode_q;
  chc_op_t      op_q;
  chc_step_t    step;
  chc_apb_req_t req_q;
  logic [3:0]   idx_q;
  logic [1:0]   mb_q;
  logic         fifo_q;
  logic         busy_q;
  logic         done_q;
  logic         err_q;
  logic [31:0]  timing_q;
  logic [5:0]   options_q;
  logic [31:0]  fmode_q;
  logic [31:0]  fscale_q;
  logic [31:0]  fassign_q;
  logic [31:0]  fact_q;
  logic [3:0]   fidx_q;
  logic [31:0]  fval1_q;
  logic [31:0]  fval2_q;
  logic [31:0]  tx_q [4];
  logic [31:0]  rx_q [4];
  logic [31:0]  prdata_q;
  logic         pready_q;
  logic         pslverr_q;
  logic [31:0]  rd_data;
  logic         mapped;
  logic         wr_en;
  logic         cmd_take;
  logic         xfer_end;
  logic [4:0]   quanta;
  logic [31:0]  opt_word;
  logic [2:0]   empty_bits;
  logic [1:0]   wsel;
  logic [11:0]  mb_base;
  logic [11:0]  rx_base;
  logic [11:0]  rff_addr;
  logic [11:0]  filt_addr;

  // ----------------------------------------------------------------
  // Slave side decode
  // ----------------------------------------------------------------
  assign wr_en    = psel & penable & pready_q & pwrite;
  assign cmd_take = wr_en & (paddr == `CHC_REG_CMD) & (state_q == CHC_S_IDLE);
  assign xfer_end = (state_q == CHC_S_ACCESS) & m_rsp.pready;

  // Quanta per bit: sync + first + second segment
  assign quanta = 5'(timing_q[`CHC_BTIM_TS1_LSB +: 4]) + 5'(timing_q[`CHC_BTIM_TS2_LSB +: 3]) + 5'h03;

  // Behaviour options sit above init and sleep requests
  assign opt_word   = {24'h0, options_q, 2'b00};
  assign wsel       = 2'(idx_q - 4'h1);
  assign mb_base    = `CHC_DEV_TX_BASE + {6'h00, mb_q, 4'h0};
  assign rx_base    = `CHC_DEV_RX_BASE + {7'h00, fifo_q, 4'h0};
  assign rff_addr   = fifo_q ? `CHC_DEV_RFF1 : `CHC_DEV_RFF0;
  assign filt_addr  = `CHC_DEV_FILT_BASE + {5'h00, fidx_q, 3'h0};
  assign empty_bits = m_rsp.prdata[`CHC_TSTS_EMPTY_LSB +: 3];

  // Step table for each sequence
  always_comb begin
    step = '{kind: CHC_K_END, addr: 12'h000, wdata: 32'h0, poll: 1'b0, poll_val: 1'b0};
    unique case (op_q)
      CHC_OP_CFG: begin
        unique case (idx_q)
          4'h0: step = '{CHC_K_WR, `CHC_DEV_MCTRL, opt_word, 1'b0, 1'b0};
          4'h1: step = '{CHC_K_WR, `CHC_DEV_MCTRL, opt_word | 32'h1, 1'b0, 1'b0};
          4'h2: step = '{CHC_K_RD, `CHC_DEV_MSTS, 32'h0, 1'b1, 1'b1};
          4'h3: step = '{CHC_K_WR, `CHC_DEV_BTIM, timing_q & `CHC_BTIM_MASK, 1'b0, 1'b0};
          4'h4: step = '{CHC_K_WR, `CHC_DEV_MCTRL, opt_word, 1'b0, 1'b0};
          4'h5: step = '{CHC_K_RD, `CHC_DEV_MSTS, 32'h0, 1'b1, 1'b0};
          4'h6: step = '{CHC_K_WR, `CHC_DEV_FMC, 32'h1, 1'b0, 1'b0};
          4'h7: step = '{CHC_K_WR, `CHC_DEV_FM1, fmode_q, 1'b0, 1'b0};
          4'h8: step = '{CHC_K_WR, `CHC_DEV_FS1, fscale_q, 1'b0, 1'b0};
          4'h9: step = '{CHC_K_WR, `CHC_DEV_FFA1, fassign_q, 1'b0, 1'b0};
          4'ha: step = '{CHC_K_WR, filt_addr, fval1_q, 1'b0, 1'b0};
          4'hb: step = '{CHC_K_WR, filt_addr + 12'h004, fval2_q, 1'b0, 1'b0};
          4'hc: step = '{CHC_K_WR, `CHC_DEV_FA1, fact_q, 1'b0, 1'b0};
          4'hd: step = '{CHC_K_WR, `CHC_DEV_FMC, 32'h0, 1'b0, 1'b0};
          default: step.kind = CHC_K_END;
        endcase
      end
      CHC_OP_TX: begin
        unique case (idx_q)
          4'h0: step = '{CHC_K_RD, `CHC_DEV_TSTS, 32'h0, 1'b0, 1'b0};
          4'h1: step = '{CHC_K_WR, mb_base, tx_q[0] & ~32'h1, 1'b0, 1'b0};
          4'h2, 4'h3, 4'h4: step = '{CHC_K_WR, mb_base + {8'h00, wsel, 2'b00}, tx_q[wsel], 1'b0, 1'b0};
          4'h5: step = '{CHC_K_WR, mb_base, tx_q[0] | 32'h1, 1'b0, 1'b0};
          default: step.kind = CHC_K_END;
        endcase
      end
      CHC_OP_RX: begin
        unique case (idx_q)
          4'h0: step = '{CHC_K_RD, rff_addr, 32'h0, 1'b0, 1'b0};
          4'h1, 4'h2, 4'h3, 4'h4: step = '{CHC_K_RD, rx_base + {8'h00, wsel, 2'b00}, 32'h0, 1'b0, 1'b0};
          4'h5: step = '{CHC_K_WR, rff_addr, 32'h1 << `CHC_RFF_REL_BIT, 1'b0, 1'b0};
          default: step.kind = CHC_K_END;
        endcase
      end
      default: step.kind = CHC_K_END;
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  // State, step index and operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= CHC_S_IDLE;
      op_q    <= CHC_OP_CFG;
      idx_q   <= 4'h0;
      fifo_q  <= 1'b0;
    end else begin
      unique case (state_q)
        CHC_S_IDLE: begin
          if (cmd_take && (pwdata[2:0] != 3'h0)) begin
            // Traffic only once the device runs normally
            state_q <= (pwdata[`CHC_CMD_CFG_BIT] || (mode_q == CHC_M_NORMAL)) ? CHC_S_STEP : CHC_S_IDLE;
            idx_q   <= 4'h0;
            fifo_q  <= pwdata[`CHC_CMD_FIFO_BIT];
            op_q    <= pwdata[`CHC_CMD_CFG_BIT] ? CHC_OP_CFG : (pwdata[`CHC_CMD_TX_BIT] ? CHC_OP_TX : CHC_OP_RX);
          end
        end
        CHC_S_STEP:  state_q <= (step.kind == CHC_K_END) ? CHC_S_IDLE : CHC_S_SETUP;
        CHC_S_SETUP: state_q <= CHC_S_ACCESS;
        CHC_S_ACCESS: begin
          if (m_rsp.pready) begin
            state_q <= CHC_S_STEP;
            if (m_rsp.pslverr) begin
              state_q <= CHC_S_IDLE;
            end else if (step.poll && (m_rsp.prdata[`CHC_MSTS_ACK_BIT] != step.poll_val)) begin
              idx_q <= idx_q; // Poll again
            end else if ((op_q == CHC_OP_TX) && (idx_q == 4'h0) && (empty_bits == 3'h0)) begin
              state_q <= CHC_S_IDLE;
            end else if ((op_q == CHC_OP_RX) && (idx_q == 4'h0)
                         && (m_rsp.prdata[`CHC_RFF_PEND_LSB +: 2] == 2'h0)) begin
              state_q <= CHC_S_IDLE;
            end else begin
              idx_q <= idx_q + 4'h1;
            end
          end
        end
        default: state_q <= CHC_S_IDLE;
      endcase
    end
  end

  // Master request: setup cycle, then access until pready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q <= '0;
    end else if ((state_q == CHC_S_STEP) && (step.kind != CHC_K_END)) begin
      req_q.psel    <= 1'b1;
      req_q.penable <= 1'b0;
      req_q.pwrite  <= (step.kind == CHC_K_WR);
      req_q.paddr   <= step.addr;
      req_q.pwdata  <= step.wdata;
    end else if (state_q == CHC_S_SETUP) begin
      req_q.penable <= 1'b1;
    end else if (xfer_end) begin
      req_q.psel    <= 1'b0;
      req_q.penable <= 1'b0;
    end
  end

  // Free transmit mailbox, lowest index first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mb_q <= 2'h0;
    end else if (xfer_end && (op_q == CHC_OP_TX) && (idx_q == 4'h0)) begin
      mb_q <= empty_bits[0] ? 2'h0 : (empty_bits[1] ? 2'h1 : 2'h2);
    end
  end

  // Received frame words
  generate
    for (genvar gi = 0; gi < 4; gi++) begin : g_rx
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rx_q[gi] <= 32'h0;
        end else if (xfer_end && (op_q == CHC_OP_RX) && (idx_q == 4'(gi + 1))) begin
          rx_q[gi] <= m_rsp.prdata;
        end
      end
    end
  endgenerate

  // Device mode tracking
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= CHC_M_SLEEP;
    end else if (xfer_end && !m_rsp.pslverr && (op_q == CHC_OP_CFG)) begin
      if (idx_q == 4'h0) begin
        mode_q <= CHC_M_AWAKE;
      end else if ((idx_q == 4'h2) && m_rsp.prdata[`CHC_MSTS_ACK_BIT]) begin
        mode_q <= CHC_M_INIT;
      end else if ((idx_q == 4'h5) && !m_rsp.prdata[`CHC_MSTS_ACK_BIT]) begin
        mode_q <= CHC_M_NORMAL;
      end
    end
  end

  // Busy, done and error flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      err_q  <= 1'b0;
    end else if (cmd_take && (pwdata[2:0] != 3'h0)) begin
      busy_q <= pwdata[`CHC_CMD_CFG_BIT] || (mode_q == CHC_M_NORMAL);
      done_q <= !pwdata[`CHC_CMD_CFG_BIT] && (mode_q != CHC_M_NORMAL);
      err_q  <= !pwdata[`CHC_CMD_CFG_BIT] && (mode_q != CHC_M_NORMAL);
    end else if (xfer_end && m_rsp.pslverr) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
      err_q  <= 1'b1;
    end else if (xfer_end && (idx_q == 4'h0) && (((op_q == CHC_OP_TX) && (empty_bits == 3'h0))
                 || ((op_q == CHC_OP_RX) && (m_rsp.prdata[`CHC_RFF_PEND_LSB +: 2] == 2'h0)))) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
      err_q  <= 1'b1;
    end else if ((state_q == CHC_S_STEP) && (step.kind == CHC_K_END)) begin
      busy_q <= 1'b0;
      done_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Own registers
  // ----------------------------------------------------------------
  // Configuration held while a sequence runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timing_q  <= `CHC_TIMING_RESET;
      options_q <= 6'h00;
      fmode_q   <= 32'h0;
      fscale_q  <= 32'h0;
      fassign_q <= 32'h0;
      fact_q    <= 32'h0;
      fidx_q    <= 4'h0;
      fval1_q   <= 32'h0;
      fval2_q   <= 32'h0;
    end else if (wr_en && !busy_q) begin
      unique case (paddr)
        `CHC_REG_TIMING:  timing_q  <= pwdata & `CHC_BTIM_MASK;
        `CHC_REG_OPTIONS: options_q <= pwdata[5:0];
        `CHC_REG_FMODE:   fmode_q   <= pwdata;
        `CHC_REG_FSCALE:  fscale_q  <= pwdata;
        `CHC_REG_FASSIGN: fassign_q <= pwdata;
        `CHC_REG_FACT:    fact_q    <= pwdata;
        `CHC_REG_FIDX:    fidx_q    <= pwdata[3:0];
        `CHC_REG_FVAL1:   fval1_q   <= pwdata;
        `CHC_REG_FVAL2:   fval2_q   <= pwdata;
        default: ;
      endcase
    end
  end

  // Frame words for transmission
  generate
    for (genvar gt = 0; gt < 4; gt++) begin : g_tx
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          tx_q[gt] <= 32'h0;
        end else if (wr_en && !busy_q && (paddr == {`CHC_REG_TX_HI, 2'(gt), 2'b00})) begin
          tx_q[gt] <= pwdata;
        end
      end
    end
  endgenerate

  // Read mux
  always_comb begin
    rd_data = 32'h0;
    mapped  = 1'b1;
    if (paddr[1:0] != 2'b00) begin
      mapped = 1'b0;
    end else if (paddr[7:4] == `CHC_REG_TX_HI) begin
      rd_data = tx_q[paddr[3:2]];
    end else if (paddr[7:4] == `CHC_REG_RX_HI) begin
      rd_data = rx_q[paddr[3:2]];
    end else begin
      unique case (paddr)
        `CHC_REG_CMD:     rd_data = 32'h0;
        `CHC_REG_STATUS:  rd_data = {8'h00, 4'h0, mode_q, 3'h0, quanta, 3'h0, mb_q, err_q, done_q, busy_q};
        `CHC_REG_TIMING:  rd_data = timing_q;
        `CHC_REG_OPTIONS: rd_data = {26'h0, options_q};
        `CHC_REG_FMODE:   rd_data = fmode_q;
        `CHC_REG_FSCALE:  rd_data = fscale_q;
        `CHC_REG_FASSIGN: rd_data = fassign_q;
        `CHC_REG_FACT:    rd_data = fact_q;
        `CHC_REG_FIDX:    rd_data = {28'h0, fidx_q};
        `CHC_REG_FVAL1:   rd_data = fval1_q;
        `CHC_REG_FVAL2:   rd_data = fval2_q;
        default:          mapped  = 1'b0;
      endcase
    end
  end

  // Slave answer: one access cycle, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0 : rd_data;
      pready_q  <= 1'b1;
      pslverr_q <= !mapped || (paddr[7:4] == `CHC_REG_RX_HI && pwrite);
    end else begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign m_req   = req_q;

endmodule // chc_host

// [chc_host_asserts.sv]
// Checker for the CAN host controller ports
`timescale 1ns/100ps
`include "chc_consts.svh"
module chc_host_asserts
  import chc_pkg::*;
(
  input wire logic          pclk,
  input wire logic          presetn,
  input wire logic          psel,
  input wire logic          penable,
  input wire logic          pwrite,
  input wire logic [7:0]    paddr,
  input wire logic [31:0]   pwdata,
  input wire logic [31:0]   prdata,
  input wire logic          pready,
  input wire logic          pslverr,
  input chc_apb_req_t       m_req,
  input chc_apb_rsp_t       m_rsp
);
  logic        cmd_q, wr_q, init_q, ack_q, lock_q;
  logic [2:0]  tsts_q, rxn_q;
  logic        done, dwr, drd;
  logic [11:0] da;

  // Completed device transfers
  assign done = m_req.psel && m_req.penable && m_rsp.pready;
  assign dwr  = done && m_req.pwrite;
  assign drd  = done && !m_req.pwrite;
  assign da   = m_req.paddr;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Device state as seen on the bus
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {cmd_q, wr_q, init_q, ack_q, lock_q, tsts_q, rxn_q} <= '0;
    end else begin
      if (psel && penable && pready && pwrite && paddr == `CHC_REG_CMD) cmd_q <= 1'b1;
      if (dwr) wr_q <= 1'b1;
      if (dwr && da == `CHC_DEV_MCTRL) init_q <= m_req.pwdata[0];
      if (dwr && da == `CHC_DEV_FMC) lock_q <= m_req.pwdata[0];
      if (drd && da == `CHC_DEV_MSTS) ack_q <= m_rsp.prdata[0];
      if (drd && da == `CHC_DEV_TSTS) tsts_q <= m_rsp.prdata[28:26];
      if (drd && (da == `CHC_DEV_RFF0 || da == `CHC_DEV_RFF1)) rxn_q <= 3'h0;
      else if (drd && da >= `CHC_DEV_RX_BASE && da < 12'h1d0) rxn_q <= rxn_q + 3'h1;
    end
  end

  property p_quiet; !cmd_q |-> !m_req.psel; endproperty
  a_quiet: assert property (p_quiet) else $error("device access before command");
  property p_wake; $rose(m_req.psel) && !wr_q |-> m_req.pwrite && da == `CHC_DEV_MCTRL && !m_req.pwdata[1]; endproperty
  a_wake: assert property (p_wake) else $error("first access not a wake");
  property p_poll; dwr && da == `CHC_DEV_MCTRL && m_req.pwdata[0] |-> ##[2:4] drd == 1'b0 && m_req.psel && !m_req.pwrite && da == `CHC_DEV_MSTS; endproperty
  a_poll: assert property (p_poll) else $error("no poll after init request");
  property p_btim; dwr && da == `CHC_DEV_BTIM |-> init_q && ack_q; endproperty
  a_btim: assert property (p_btim) else $error("timing written outside init");
  property p_leave; dwr && da == `CHC_DEV_FMC && m_req.pwdata[0] |-> !init_q && !ack_q; endproperty
  a_leave: assert property (p_leave) else $error("filters set before init left");
  property p_lock; dwr && da >= `CHC_DEV_FM1 && da < 12'h2c0 && da != `CHC_DEV_FA1 |-> lock_q; endproperty
  a_lock: assert property (p_lock) else $error("filter write without lock");
  property p_tx; dwr && da >= `CHC_DEV_TX_BASE && da < `CHC_DEV_RX_BASE |-> tsts_q[da[5:4]]; endproperty
  a_tx: assert property (p_tx) else $error("mailbox written while full");
  property p_rel; dwr && (da == `CHC_DEV_RFF0 || da == `CHC_DEV_RFF1) |-> m_req.pwdata[5] && rxn_q == 3'h4; endproperty
  a_rel: assert property (p_rel) else $error("release before four reads");
  property p_err; psel && !penable && paddr[1:0] != 2'h0 |=> pready && pslverr; endproperty
  a_err: assert property (p_err) else $error("unaligned access accepted");
  property p_hold; m_req.psel && !done |=> m_req.psel && $stable(m_req.paddr) && $stable(m_req.pwdata); endproperty
  a_hold: assert property (p_hold) else $error("device request dropped");
endmodule // chc_host_asserts

bind chc_host chc_host_asserts chc_host_asserts_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .m_req(m_req), .m_rsp(m_rsp));

// [chc_dev_model.sv]
// Device model: modes, bit timing, filter bank, mailboxes, receive FIFOs
`timescale 1ns/100ps
`include "chc_consts.svh"
module chc_dev_model
  import chc_pkg::*;
(
  input wire logic  pclk,
  input wire logic  presetn,
  input wire logic  slow,
  input chc_apb_req_t m_req,
  output chc_apb_rsp_t m_rsp
);
  logic [31:0]  mctrl, btim, fmc, fm, fs, ffa, fa, rd, d;
  logic [31:0]  txm [12];
  logic [31:0]  fv [32];
  logic [127:0] rx [2][$];
  logic [2:0]   empty;
  logic         ack, fault = 1'b0;
  logic [11:0]  a, w;
  int           cnt, f;

  // Frame arrival, refused asleep, in init, under filter lock or when full
  task automatic push(input int q, input logic [127:0] fr);
    if (!mctrl[1] && !mctrl[0] && !fmc[0] && rx[q].size() < 3) rx[q].push_back(fr);
  endtask

  // Register access with optional wait states
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mctrl = 32'h0000_0002;
      {btim, fmc, fm, fs, ffa, fa} = '0;
      ack = 1'b0;
      cnt = 0;
      empty = 3'h7;
      rx[0].delete();
      rx[1].delete();
      m_rsp <= '0;
    end else if (m_req.psel && m_req.penable && !m_rsp.pready && cnt < (slow ? 3 : 0)) begin
      cnt++;
      m_rsp.prdata <= ~m_rsp.prdata;
    end else if (m_req.psel && m_req.penable && !m_rsp.pready) begin
      cnt = 0;
      a = m_req.paddr;
      d = m_req.pwdata;
      w = a - `CHC_DEV_FILT_BASE;
      f = (a == `CHC_DEV_RFF1 || a >= 12'h1c0) ? 1 : 0;
      rd = '0;
      if (m_req.pwrite) begin
        if (a == `CHC_DEV_MCTRL) mctrl = d;
        if (a == `CHC_DEV_BTIM && ack) btim = d & `CHC_BTIM_MASK;
        if (a == `CHC_DEV_FMC) fmc = d;
        if (fmc[0] && a == `CHC_DEV_FM1) fm = d;
        if (fmc[0] && a == `CHC_DEV_FS1) fs = d;
        if (fmc[0] && a == `CHC_DEV_FFA1) ffa = d;
        if (a == `CHC_DEV_FA1) fa = d;
        if (a >= `CHC_DEV_FILT_BASE && a < 12'h2c0 && (fmc[0] || !fa[w[6:3]])) fv[w[6:2]] = d;
        if (a >= `CHC_DEV_TX_BASE && a < `CHC_DEV_RX_BASE && empty[a[5:4]]) begin
          txm[a[5:2]] = d;
          if (a[3:0] == 4'h0 && d[0]) empty[a[5:4]] = 1'b0;
        end
        if ((a == `CHC_DEV_RFF0 || a == `CHC_DEV_RFF1) && d[5] && rx[f].size() > 0) void'(rx[f].pop_front());
      end else begin
        if (a == `CHC_DEV_MSTS) rd[0] = ack;
        if (a == `CHC_DEV_MSTS) ack = mctrl[0] && !mctrl[1];
        if (a == `CHC_DEV_TSTS) rd[28:26] = empty;
        if (a == `CHC_DEV_RFF0 || a == `CHC_DEV_RFF1) rd[1:0] = 2'(rx[f].size());
        if (a >= `CHC_DEV_RX_BASE && a < 12'h1d0 && rx[f].size() > 0) rd = rx[f][0][a[3:2] * 32 +: 32];
        if (a == `CHC_DEV_BTIM) rd = btim;
      end
      m_rsp <= {1'b1, fault, rd};
    end else begin
      cnt = 0;
      m_rsp.pready <= 1'b0;
      m_rsp.prdata <= ~m_rsp.prdata;
    end
  end
endmodule // chc_dev_model

// [chc_host_tb_top.sv]
// Testbench: host controller against the device model
`timescale 1ns/100ps
`include "chc_consts.svh"
module chc_host_tb_top
  import chc_pkg::*;
();
  logic         pclk, presetn, psel, penable, pwrite, slow, pready, pslverr, ev;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, rv, exp;
  logic [31:0]  lf = 32'h0000_0019;
  logic [31:0]  cfg [9];
  logic [127:0] fr;
  logic [127:0] exq [2][$];
  chc_apb_req_t m_req;
  chc_apb_rsp_t m_rsp;
  int           mismatches, n_compared, empty, k, f, mb;

  chc_host chc_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .m_req(m_req),
    .m_rsp(m_rsp));
  chc_dev_model chc_dev_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow), .m_req(m_req), .m_rsp(m_rsp));

  // Clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] rnd();
    for (int i = 0; i < 32; i++) lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Issue a command and poll until it has finished
  task automatic cmd(input logic [31:0] c);
    apb(1'b1, `CHC_REG_CMD, c);
    do apb(1'b0, `CHC_REG_STATUS, 32'h0);
    while (rv[0] !== 1'b0 || rv[1] !== 1'b1);
  endtask

  task automatic end_of_test();
    $display("compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge pclk);
    mismatches++;
    $display("[FAIL] t=%0t watchdog expired", $time);
    end_of_test();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, slow, paddr, pwdata} = '0;
    {mismatches, n_compared, empty} = {32'h0, 32'h0, 32'h7};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CHC_REG_STATUS, 32'h0);
    chk(rv, 32'h0001_0800);
    chc_dev_model_inst.push(0, {rnd(), rnd(), rnd(), rnd()});
    cmd(32'h2);
    chk(rv & 32'h000f_0007, 32'h0001_0006);
    apb(1'b0, 8'h05, 32'h0);
    chk({31'h0, ev}, 32'h1);
    apb(1'b0, 8'h80, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("test reset finished");
    for (int n = 0; n < 2; n++) begin
      slow <= n[0];
      for (k = 0; k < 9; k++) begin
        cfg[k] = rnd();
        apb(1'b1, 8'(8 + 4 * k), cfg[k]);
      end
      cmd(32'h1);
      exp = 32'h0008_0002 | ((32'(cfg[0][19:16]) + 32'(cfg[0][22:20]) + 32'h3) << 8);
      chk(rv & 32'h000f_1f07, exp);
      chk(chc_dev_model_inst.btim, cfg[0] & `CHC_BTIM_MASK);
      chk(chc_dev_model_inst.mctrl, {24'h0, cfg[1][5:0], 2'b00});
      chk(chc_dev_model_inst.fm, cfg[2]);
      chk(chc_dev_model_inst.fs, cfg[3]);
      chk(chc_dev_model_inst.ffa, cfg[4]);
      chk(chc_dev_model_inst.fa, cfg[5]);
      chk(chc_dev_model_inst.fv[{cfg[6][3:0], 1'b0}], cfg[7]);
      chk(chc_dev_model_inst.fv[{cfg[6][3:0], 1'b1}], cfg[8]);
      chk({31'h0, chc_dev_model_inst.fmc[0]}, 32'h0);
      $display("test config finished");
    end
    // Transmit until no mailbox is free
    for (int n = 0; n < 4; n++) begin
      slow <= n[0];
      for (k = 0; k < 4; k++) begin
        cfg[k] = rnd();
        apb(1'b1, 8'(8'h30 + 4 * k), cfg[k]);
      end
      cmd(32'h2);
      mb = -1;
      for (k = 2; k >= 0; k--) if (empty[k]) mb = k;
      if (mb >= 0) begin
        chk(rv & 32'h1f, {27'h0, mb[1:0], 3'h2});
        empty &= ~(1 << mb);
        for (k = 0; k < 4; k++) chk(chc_dev_model_inst.txm[mb * 4 + k], k == 0 ? cfg[0] | 32'h1 : cfg[k]);
      end else chk(rv & 32'h7, 32'h6);
      chk({29'h0, chc_dev_model_inst.empty}, 32'(empty));
    end
    $display("test transmit finished");
    // Receive: overfill FIFO 0, one frame into FIFO 1, drain each past empty
    for (int n = 0; n < 5; n++) begin
      fr = {rnd(), rnd(), rnd(), rnd()};
      f = (n == 4) ? 1 : 0;
      chc_dev_model_inst.push(f, fr);
      if (exq[f].size() < 3) exq[f].push_back(fr);
    end
    // Device error aborts the drain, nothing released
    chc_dev_model_inst.fault <= 1'b1;
    cmd(32'h4);
    chk(rv & 32'h7, 32'h6);
    chc_dev_model_inst.fault <= 1'b0;
    for (int n = 0; n < 6; n++) begin
      f = (n > 3) ? 1 : 0;
      slow <= n[0];
      cmd({28'h0, f[0], 3'h4});
      if (exq[f].size() > 0) begin
        chk(rv & 32'h7, 32'h2);
        for (k = 0; k < 4; k++) begin
          apb(1'b0, 8'(8'h40 + 4 * k), 32'h0);
          chk(rv, exq[f][0][k * 32 +: 32]);
        end
        void'(exq[f].pop_front());
      end else chk(rv & 32'h7, 32'h6);
    end
    apb(1'b1, 8'h40, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("test receive finished");
    // Reset again mid-run
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CHC_REG_STATUS, 32'h0);
    chk(rv, 32'h0001_0800);
    $display("test second reset finished");
    end_of_test();
  end
endmodule // chc_host_tb_top
